// [rtl/rxlcp_regs.sv]
// receive link mode and indirect channel provisioning register bank
`timescale 1ns/1ps
module rxlcp_regs #(
   parameter int CHANNELS = 256,
   parameter int FIRST_LINK = 3,
   parameter int LINKS = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fifo fill level per channel in bytes, from the buffer
   input wire logic [15:0] fifo_fill_bytes [CHANNELS],
   // receive clock gap seen on each link, from a pin domain
   input wire logic [LINKS-1:0] link_rx_clk,
   // decoded link configuration
   output rxlcp_pkg::rxlcp_link_s link_cfg [LINKS],
   output logic [LINKS-1:0] link_byte_start,
   // channel provisioning to the hdlc processor
   output rxlcp_pkg::rxlcp_entry_s chan_cfg [CHANNELS],
   output logic [CHANNELS-1:0] chan_checksum_off
);
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      RXLCP_IDLE = 2'b00,
      RXLCP_WRITE = 2'b01,
      RXLCP_READ = 2'b10
   } rxlcp_state_e;

   rxlcp_state_e state;
   logic [2:0] mode [LINKS];
   logic [LINKS-1:0] byte_align_enable;
   logic [7:0] indirect_channel_number;
   logic indirect_read_not_write;
   logic busy;
   logic [1:0] wait_cnt;
   rxlcp_pkg::rxlcp_entry_s data_reg;
   logic transfer_ready_flag;
   rxlcp_pkg::rxlcp_entry_s ram [CHANNELS];
   logic wr_en;
   logic rd_en;
   logic [LINKS-1:0] clk_s1;
   logic [LINKS-1:0] clk_s2;
   logic [LINKS-1:0] clk_s3;
   logic [6:0] gap_cnt [LINKS];

   // decode of a register byte address into a link index
   function automatic logic [4:0] link_index(input logic [11:0] a);
      logic [11:0] d;
      d = a - 12'h180;
      return d[6:2];
   endfunction

   localparam logic [15:0] BLOCK_BYTES_W = 16'(rxlcp_pkg::BLOCK_BYTES);

   // threshold in bytes for a transfer size field
   function automatic logic [15:0] xfer_bytes(input logic [3:0] x);
      return 16'(BLOCK_BYTES_W * ({12'h000, x} + 16'h0001));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // apb: zero wait state, whole-word writes when any lane set
   assign wr_en = psel && penable && pwrite && (pstrb != 4'h0);
   assign rd_en = psel && penable && !pwrite;

   // handshake outputs are registered so they come from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
      end
   end

   // read data prepared during setup so it lands with pready
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr >= rxlcp_pkg::LINK_CFG_FIRST &&
             paddr <= rxlcp_pkg::LINK_CFG_LAST) begin
            prdata[2:0] <= mode[link_index(paddr)];
         end else if (paddr == rxlcp_pkg::CHAN_SEL_ADDR) begin
            prdata[rxlcp_pkg::SEL_BUSY_BIT] <= busy;
            prdata[rxlcp_pkg::SEL_RNW_BIT] <= indirect_read_not_write;
            prdata[7:0] <= indirect_channel_number;
         end else if (paddr == rxlcp_pkg::CHAN_DATA1_ADDR) begin
            // pointer is write only and reads zero
            prdata[rxlcp_pkg::D1_PROVISION_ENABLE_BIT] <= data_reg.provision_enable;
            prdata[rxlcp_pkg::D1_CHECKSUM_DISCARD_BIT] <= data_reg.checksum_discard;
            prdata[rxlcp_pkg::D1_DELINEATION_ENABLE_BIT] <= data_reg.delineation_enable;
            prdata[rxlcp_pkg::D1_TREADY_BIT] <= transfer_ready_flag;
         end else if (paddr == rxlcp_pkg::XFER_CFG_ADDR) begin
            prdata[3:0] <= data_reg.xfer;
         end else if (paddr == rxlcp_pkg::BYTE_ALIGN_ADDR) begin
            prdata <= 32'(byte_align_enable);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link mode registers; links below the first are not addressable and keep MODE_RESET
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LINKS; i++) mode[i] <= rxlcp_pkg::MODE_RESET;
         byte_align_enable <= '0;
      end else if (wr_en) begin
         if (paddr >= rxlcp_pkg::LINK_CFG_FIRST &&
             paddr <= rxlcp_pkg::LINK_CFG_LAST) begin
            mode[link_index(paddr)] <= pwdata[2:0];
         end else if (paddr == rxlcp_pkg::BYTE_ALIGN_ADDR) begin
            byte_align_enable <= pwdata[LINKS-1:0];
         end
      end
   end

   // per-link decode for the channel assigner
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LINKS; i++) link_cfg[i] <= '0;
      end else begin
         for (int i = 0; i < LINKS; i++) begin
            link_cfg[i].slot_link <= 5'(i);
            link_cfg[i].accept <= 1'b1;
            link_cfg[i].byte_align <= 1'b0;
            case (mode[i])
               rxlcp_pkg::RXLCP_UNCHAN: begin
                  link_cfg[i].slot_count <= 5'd0;
                  link_cfg[i].byte_align <= byte_align_enable[i];
               end
               rxlcp_pkg::RXLCP_T1J1: link_cfg[i].slot_count <= 5'd23;
               rxlcp_pkg::RXLCP_E1: link_cfg[i].slot_count <= 5'd30;
               rxlcp_pkg::RXLCP_HMVIP2: link_cfg[i].slot_count <= 5'd31;
               rxlcp_pkg::RXLCP_HMVIP8: begin
                  link_cfg[i].slot_count <= 5'd31;
                  // only the group leader carries data; group k of
                  // 32 slots lands on link 4m+k
                  link_cfg[i].accept <= (i % 4 == 0);
               end
               default: begin
                  link_cfg[i].slot_count <= 5'd0;
                  link_cfg[i].accept <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive clock synchronisers for gap detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_s1 <= '0;
         clk_s2 <= '0;
         clk_s3 <= '0;
      end else begin
         clk_s1 <= link_rx_clk;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
      end
   end

   // pause counter: first rising edge after a long pause marks msb
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LINKS; i++) gap_cnt[i] <= 7'h00;
         link_byte_start <= '0;
      end else begin
         for (int i = 0; i < LINKS; i++) begin
            link_byte_start[i] <= 1'b0;
            if (clk_s2[i] && !clk_s3[i]) begin
               gap_cnt[i] <= 7'h00;
               if (gap_cnt[i] >= 7'(rxlcp_pkg::PAUSE_CYCLES) &&
                   link_cfg[i].byte_align)
                  link_byte_start[i] <= 1'b1;
            end else if (gap_cnt[i] != 7'h7f) begin
               gap_cnt[i] <= gap_cnt[i] + 7'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // indirect access control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= RXLCP_IDLE;
         busy <= 1'b0;
         wait_cnt <= 2'h0;
         indirect_channel_number <= rxlcp_pkg::CHAN_RESET;
         indirect_read_not_write <= 1'b0;
      end else begin
         case (state)
            RXLCP_IDLE: begin
               // a trigger during an access is dropped, not queued
               if (wr_en && paddr == rxlcp_pkg::CHAN_SEL_ADDR) begin
                  indirect_channel_number <= pwdata[7:0];
                  indirect_read_not_write <= pwdata[rxlcp_pkg::SEL_RNW_BIT];
                  busy <= 1'b1;
                  wait_cnt <= 2'(rxlcp_pkg::RAM_ACCESS_CYCLES - 1);
                  state <= pwdata[rxlcp_pkg::SEL_RNW_BIT] ?
                           RXLCP_READ : RXLCP_WRITE;
               end
            end
            RXLCP_WRITE, RXLCP_READ: begin
               if (wait_cnt == 2'h0) begin
                  busy <= 1'b0;
                  state <= RXLCP_IDLE;
               end else begin
                  wait_cnt <= wait_cnt - 2'h1;
               end
            end
            default: state <= RXLCP_IDLE;
         endcase
      end
   end

   // data register: software writes, or the entry on read completion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg <= '0;
         transfer_ready_flag <= 1'b0;
      end else if (state == RXLCP_READ && wait_cnt == 2'h0) begin
         data_reg <= ram[indirect_channel_number];
         transfer_ready_flag <= fifo_fill_bytes[indirect_channel_number] >=
            xfer_bytes(ram[indirect_channel_number].xfer);
      end else if (wr_en && paddr == rxlcp_pkg::CHAN_DATA1_ADDR) begin
         data_reg.provision_enable <= pwdata[rxlcp_pkg::D1_PROVISION_ENABLE_BIT];
         data_reg.checksum_discard <= pwdata[rxlcp_pkg::D1_CHECKSUM_DISCARD_BIT];
         data_reg.delineation_enable <= pwdata[rxlcp_pkg::D1_DELINEATION_ENABLE_BIT];
         data_reg.fptr <= pwdata[10:0];
      end else if (wr_en && paddr == rxlcp_pkg::XFER_CFG_ADDR) begin
         data_reg.xfer <= pwdata[3:0];
      end
   end

   // provision ram, written at the end of an indirect write
   always_ff @(posedge clk) begin
      if (state == RXLCP_WRITE && wait_cnt == 2'h0)
         ram[indirect_channel_number] <= data_reg;
   end

   ////////////////////////////////////////////////////////////////////
   // per-channel controls to the hdlc processor
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < CHANNELS; c++) chan_cfg[c] <= '0;
         chan_checksum_off <= '0;
      end else if (state == RXLCP_WRITE && wait_cnt == 2'h0) begin
         // provision_enable gates processing; delineation_enable off means raw pass-through
         chan_cfg[indirect_channel_number] <= data_reg;
         // checksum_discard honoured only while delineating
         chan_checksum_off[indirect_channel_number] <=
            data_reg.delineation_enable && data_reg.checksum_discard;
      end
   end
endmodule

// [rtl/rxlcp_pkg.sv]
// constants, types and layouts shared by the receive provisioning block
package rxlcp_pkg;
   // register byte addresses
   localparam logic [11:0] LINK_CFG_FIRST = 12'h18c;
   localparam logic [11:0] LINK_CFG_LAST = 12'h1fc;
   localparam logic [11:0] CHAN_SEL_ADDR = 12'h200;
   localparam logic [11:0] CHAN_DATA1_ADDR = 12'h204;
   localparam logic [11:0] XFER_CFG_ADDR = 12'h208;
   localparam logic [11:0] BYTE_ALIGN_ADDR = 12'h20c;
   // field positions
   localparam int SEL_BUSY_BIT = 15;
   localparam int SEL_RNW_BIT = 14;
   localparam int D1_PROVISION_ENABLE_BIT = 15;
   localparam int D1_CHECKSUM_DISCARD_BIT = 14;
   localparam int D1_DELINEATION_ENABLE_BIT = 13;
   localparam int D1_TREADY_BIT = 12;
   // reset values
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [7:0] CHAN_RESET = 8'h00;
   // timing: ram access cycles, bytes per transfer block
   localparam int RAM_ACCESS_CYCLES = 2;
   localparam int BLOCK_BYTES = 16;
   localparam int PAUSE_CYCLES = 64;
   // link modes
   typedef enum logic [2:0] {
      RXLCP_UNCHAN = 3'b000,
      RXLCP_T1J1 = 3'b001,
      RXLCP_E1 = 3'b010,
      RXLCP_HMVIP2 = 3'b011,
      RXLCP_HMVIP8 = 3'b111
   } rxlcp_mode_e;
   // one channel provision entry
   typedef struct packed {
      logic provision_enable;
      logic checksum_discard;
      logic delineation_enable;
      logic [10:0] fptr;
      logic [3:0] xfer;
   } rxlcp_entry_s;
   // per-link decoded configuration to the assigner
   typedef struct packed {
      logic accept;
      logic [4:0] slot_link;
      logic [4:0] slot_count;
      logic byte_align;
   } rxlcp_link_s;
endpackage

// [bench/rxlcp_regs_sva.sv]
// checker for the provisioning bank answers and output pulses
`timescale 1ns/1ps
module rxlcp_regs_sva #(
   parameter int CHANNELS = 256,
   parameter int LINKS = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // outputs watched
   input wire logic [LINKS-1:0] link_byte_start,
   input wire logic [CHANNELS-1:0] chan_checksum_off
);
   logic [LINKS-1:0] align_q;
   logic wr_ok;
   logic trig_wr;
   // taken writes and indirect write triggers
   assign wr_ok = psel && penable && pwrite && pready && (pstrb != 4'h0);
   assign trig_wr = wr_ok && (paddr == 12'h200) && !pwdata[14];
   ////////////////////////////////////////////////////////////////////
   // shadow of the align enables; a pulse outside it is a leak
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         align_q <= '0;
      else if (wr_ok && paddr == 12'h20c)
         align_q <= pwdata[LINKS-1:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   ////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no answer one cycle after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("answer outside an access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("answer longer than one cycle");
   a_no_slverr: assert property (!pslverr)
      else $error("error response raised");
   a_prdata_hold: assert property ($changed(prdata) |->
      $past(psel && !penable && !pwrite))
      else $error("read data moved without a read");
   a_cksum_cause: assert property ($changed(chan_checksum_off) |->
      $past(trig_wr, 2) || $past(trig_wr, 3) || $past(trig_wr, 4))
      else $error("channel config moved without a write trigger");
   a_start_single: assert property (
      (link_byte_start & $past(link_byte_start)) == '0)
      else $error("byte start longer than one cycle");
   a_start_enabled: assert property (
      (link_byte_start & ~align_q) == '0)
      else $error("byte start on a link without align");
endmodule
bind rxlcp_regs rxlcp_regs_sva #(.CHANNELS(CHANNELS), .LINKS(LINKS))
   rxlcp_regs_sva_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .link_byte_start(link_byte_start),
   .chan_checksum_off(chan_checksum_off));

// [bench/rxlcp_regs_tb.sv]
// self-checking bench for the receive provisioning register bank
`timescale 1ns/1ps
module rxlcp_regs_tb;
   typedef struct packed {
      logic [11:0] a;
      logic [2:0] m;
      logic [4:0] l;
      logic acc;
   } rxlcp_row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic [31:0] prdata, rd, hits;
   logic pready, pslverr, keep;
   logic [15:0] fill [256];
   logic [31:0] rx_clk = '0;
   logic [31:0] byte_start;
   rxlcp_pkg::rxlcp_link_s link_cfg [32];
   rxlcp_pkg::rxlcp_entry_s chan_cfg [256];
   logic [255:0] cks_off;
   int n_fail = 0;
   int check_count = 0;
   int i, k;
   // mode per link and whether the link takes data
   rxlcp_row_s rows [9] = '{'{12'h18c, 3'h1, 5'd3, 1'b1},
      '{12'h194, 3'h2, 5'd5, 1'b1}, '{12'h198, 3'h3, 5'd6, 1'b1},
      '{12'h19c, 3'h4, 5'd7, 1'b0}, '{12'h1a4, 3'h5, 5'd9, 1'b0},
      '{12'h1a8, 3'h6, 5'd10, 1'b0}, '{12'h1a0, 3'h7, 5'd8, 1'b1},
      '{12'h1a4, 3'h7, 5'd9, 1'b0}, '{12'h1b0, 3'h0, 5'd12, 1'b1}};
   always #20 clk = ~clk;
   rxlcp_regs rxlcp_regs_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fifo_fill_bytes(fill), .link_rx_clk(rx_clk), .link_cfg(link_cfg),
      .link_byte_start(byte_start), .chan_cfg(chan_cfg),
      .chan_checksum_off(cks_off));
   ////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one transfer; keep holds psel so a chained setup follows at once
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_fail++;
         tally_and_finish();
      end
      rd = prdata;
      penable <= 1'b0;
      if (!keep) begin
         psel <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      check(rd & m, e);
   endtask
   // poll busy under a bound, as software must
   task automatic wait_idle();
      for (i = 0; i < 20; i++) begin
         apb(1'b0, 12'h200, 32'h0, 4'h0);
         if (rd[15] === 1'b0) break;
      end
      if (i == 20) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      keep = 1'b0;
      foreach (fill[j]) fill[j] = 16'h0000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(12'h18c, 32'h7, 32'h0);
      rdchk(12'h200, 32'h40ff, 32'h0);
      rdchk(12'h300, 32'hffffffff, 32'h0);
      foreach (rows[r]) begin
         wr(rows[r].a, {29'h0, rows[r].m});
         rdchk(rows[r].a, 32'h7, {29'h0, rows[r].m});
         check(link_cfg[rows[r].l].accept, rows[r].acc);
      end
      $display("mode table done");
      // lanes: none means no write, any one means the whole word
      apb(1'b1, 12'h18c, 32'h5, 4'h0);
      rdchk(12'h18c, 32'h7, 32'h1);
      apb(1'b1, 12'h18c, 32'h0, 4'h8);
      rdchk(12'h18c, 32'h7, 32'h0);
      // indirect write of channel 5, busy seen at once
      wr(12'h204, 32'h0000e5a5);
      wr(12'h208, 32'h1);
      keep = 1'b1;
      wr(12'h200, 32'h5);
      keep = 1'b0;
      rdchk(12'h200, 32'h8000, 32'h8000);
      wait_idle();
      check(chan_cfg[5], {3'b111, 11'h5a5, 4'h1});
      check(cks_off[5], 1'b1);
      // a second trigger while busy is dropped
      wr(12'h204, 32'h0000c001);
      keep = 1'b1;
      wr(12'h200, 32'h6);
      keep = 1'b0;
      wr(12'h200, 32'h4007);
      wait_idle();
      rdchk(12'h200, 32'h40ff, 32'h6);
      check(chan_cfg[6], {3'b110, 11'h001, 4'h1});
      check(cks_off[6], 1'b0);
      $display("indirect write done");
      // written fields hold until a read; ready flag only on reads
      wr(12'h204, 32'h0);
      rdchk(12'h204, 32'he000, 32'h0);
      fill[5] <= 16'd31;
      wr(12'h200, 32'h4005);
      wait_idle();
      rdchk(12'h204, 32'hf7ff, 32'he000);
      fill[5] <= 16'd32;
      rdchk(12'h204, 32'h1000, 32'h0);
      wr(12'h200, 32'h4005);
      wait_idle();
      rdchk(12'h204, 32'h1000, 32'h1000);
      rdchk(12'h208, 32'hf, 32'h1);
      $display("indirect read done");
      // align on 3 (unchannelised) and 5 (channelised), none on 4
      wr(12'h20c, 32'h28);
      repeat (100) @(posedge clk);
      rx_clk <= 32'h38;
      hits = '0;
      repeat (20) begin
         @(posedge clk);
         hits = hits + byte_start[3] + 4 * byte_start[4];
         hits = hits + 16 * byte_start[5];
      end
      check(hits & 32'h3, 32'h1);
      check(hits >> 2, 32'h0);
      $display("byte align done");
      tally_and_finish();
   end
endmodule
